// ===== inc/ads_pkg.sv
// Package: register map, timing tables and state layout of the A/D unit
package ads_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADS_OFS_CTRL = 8'h00;     // conv_control_reg
  localparam logic [7:0] ADS_OFS_CSR = 8'h04;      // conv_ctrl_status_reg
  localparam logic [7:0] ADS_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADS_OFS_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADS_OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] ADS_OFS_RESULT0 = 8'h20;  // results at +4 each

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ADS_CTRL_SCAN_ENABLE_BIT = 0;   // scan_enable_bit
  localparam int ADS_CTRL_SCAN_SELECT_BIT = 1;   // scan_select_bit
  localparam int ADS_CTRL_CKSLO = 2;   // clock_select_lo
  localparam int ADS_CTRL_CKSHI = 3;   // clock_select_hi
  localparam int ADS_CTRL_ALTCK = 4;   // alt_clock_select
  localparam int ADS_CTRL_TRGEN = 5;   // external trigger enable
  localparam int ADS_CSR_START = 0;    // conv_start_bit
  localparam int ADS_CSR_CHLO = 1;     // channel_select_field, 4 bits
  localparam int ADS_CSR_BUSY = 5;     // conversion in progress
  localparam int ADS_RES_LSB = 6;      // result left-justified from here

  // ----------------------------------------------------------------
  // Timing tables, index {alt_clock_select, clock_select_hi, _lo}
  // ----------------------------------------------------------------
  localparam logic [9:0] ADS_DLY_MIN [8] = '{
    10'h012, 10'h00A, 10'h006, 10'h004,
    10'h003, 10'h003, 10'h003, 10'h003};
  localparam logic [3:0] ADS_DLY_SPAN [8] = '{
    4'h0, 4'h8, 4'h4, 4'h2, 4'h8, 4'h4, 4'h3, 4'h2};
  localparam logic [9:0] ADS_SPL [8] = '{
    10'h13F, 10'h09F, 10'h04F, 10'h01D,
    10'h078, 10'h03C, 10'h01E, 10'h00F};
  localparam logic [9:0] ADS_CONV_MIN [8] = '{
    10'h203, 10'h103, 10'h083, 10'h043,
    10'h145, 10'h0A5, 10'h055, 10'h02D};
  localparam logic [9:0] ADS_SCAN_CONV [8] = '{
    10'h200, 10'h100, 10'h080, 10'h040,
    10'h140, 10'h0A0, 10'h050, 10'h028};
  // Span 16 for code 00 does not fit four bits; 0 stands for 16
  localparam logic [4:0] ADS_SPAN_WRAP = 5'h10;

  // ----------------------------------------------------------------
  // Sequencer states and state record
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADS_IDLE, ADS_DELAY, ADS_SAMPLE, ADS_CONVERT
  } ads_fsm_t;

  typedef struct packed {
    logic scanEn;
    logic scanSel;
    logic [1:0] clkSel;
    logic altClk;
    logic trigEn;
  } ads_ctrl_t;

  typedef struct packed {
    ads_ctrl_t ctrl;
    logic startBit;
    logic [3:0] chSel;
    logic [3:0] phase;
    ads_fsm_t fsm;
    logic [9:0] cnt;
    logic [1:0] curCh;
    logic passDone;
    logic [3:0][15:0] result;
    logic irqStat;
    logic irqEn;
    logic irqOut;
    logic dmaReq;
    logic wbAck;
    logic [31:0] wbDat;
    logic trigMeta;
    logic trigSync;
    logic trigPrev;
    logic [9:0] datMeta;
    logic [9:0] datSync;
    logic sampleHold;
    logic [3:0] anaCh;
  } ads_state_t;

  localparam ads_state_t ADS_STATE_RST = '0;

endpackage

// ===== core/ads_unit_ctrl.sv
// Control logic of one successive-approximation A/D converter unit
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Result registers are 16-bit read-only, 10-bit result in bits 15 to 6.
// - Six low bits of every result register always read as zero.
// - Control register allows launching conversion from an external trigger.
// - Start bit set: wait start delay, sample input, then convert.
// - Start delay depends on write timing versus conversion clock phase.
// - Standard clock: first conversion 515-530/259-266/131-134/67-68 cycles.
// - Alternate clock: first conversion 325-332/165-168/85-87/45-46 cycles.
// - Sampling phase 319/159/79/29, or 120/60/30/15 with alternate clock.
// - Later scan conversions fixed 512/256/128/64, or 320/160/80/40.
// - Alternate clock exists only in units 1 and 2, never unit 0.
// - Result register chosen by scan enable and channel field; scan select is only stored and read back.
// - Scan stores channels 0-3, 4-7, 8-11 or 12-15, picked by channel field bits 3:2, in the unit's four registers.
// - Scan mode converts the four assigned channels one after another.
// - Each unit raises a conversion-end interrupt request.
// - Scan repeats continuously until software clears the start bit.
// - Enabled conversion-end event can launch a DMA transfer.
module ads_unit_ctrl
  import ads_pkg::*;
#(
  parameter int UNIT_INDEX = 0,
  parameter int RES_W = 10
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog front end
  input wire logic extTrig,
  input wire logic [RES_W-1:0] adcData,
  output logic sampleHold,
  output logic [3:0] anaChSel,
  // Events
  output logic convEndIrq,
  output logic dmaReq
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Word match of a bus address against a register offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Table index; unit 0 never sees the alternate clock
  function automatic logic [2:0] tsel(input ads_ctrl_t c);
    logic altOk;
    altOk = (UNIT_INDEX != 0);
    tsel = {c.altClk & altOk, c.clkSel};
  endfunction

  // Phase span as a five-bit count
  function automatic logic [4:0] span(input logic [2:0] t);
    span = (ADS_DLY_SPAN[t] == 4'h0) ? ADS_SPAN_WRAP : {1'b0, ADS_DLY_SPAN[t]};
  endfunction

  // ----------------------------------------------------------------
  // State and next state
  // ----------------------------------------------------------------
  ads_state_t s_q;
  ads_state_t s_d;

  logic [2:0] tIdx;
  logic [4:0] tSpan;
  logic [9:0] dlyCnt;
  logic [9:0] firstConv;
  logic [9:0] laterConv;
  logic busAcc;
  logic trigRise;
  logic irqSet;
  logic irqClr;
  logic [1:0] resIdx;
  logic [31:0] rdData;
  logic lastCh;

  // Timing figures of the current clock setting
  always_comb begin
    tIdx = tsel(s_q.ctrl);
    tSpan = span(tIdx);
    // Delay runs from min to max by the prescaler phase
    dlyCnt = ADS_DLY_MIN[tIdx]
      + {5'h00, (5'(tSpan - 5'h01) - {1'b0, s_q.phase})};
    // Convert phase after delay and sampling in the first conversion
    firstConv = ADS_CONV_MIN[tIdx] - ADS_DLY_MIN[tIdx] - ADS_SPL[tIdx];
    // Convert phase of later scan conversions, fixed length
    laterConv = ADS_SCAN_CONV[tIdx] - ADS_SPL[tIdx];
  end

  // Register read mux
  always_comb begin
    rdData = 32'h0000_0000;
    resIdx = wb_adr_i[3:2];
    if (hit(wb_adr_i, ADS_OFS_CTRL)) begin
      rdData[ADS_CTRL_SCAN_ENABLE_BIT] = s_q.ctrl.scanEn;
      rdData[ADS_CTRL_SCAN_SELECT_BIT] = s_q.ctrl.scanSel;
      rdData[ADS_CTRL_CKSLO] = s_q.ctrl.clkSel[0];
      rdData[ADS_CTRL_CKSHI] = s_q.ctrl.clkSel[1];
      rdData[ADS_CTRL_ALTCK] = s_q.ctrl.altClk;
      rdData[ADS_CTRL_TRGEN] = s_q.ctrl.trigEn;
    end else if (hit(wb_adr_i, ADS_OFS_CSR)) begin
      rdData[ADS_CSR_START] = s_q.startBit;
      rdData[ADS_CSR_CHLO +: 4] = s_q.chSel;
      rdData[ADS_CSR_BUSY] = (s_q.fsm != ADS_IDLE);
    end else if (hit(wb_adr_i, ADS_OFS_IRQ_STAT)) begin
      rdData[0] = s_q.irqStat;
    end else if (hit(wb_adr_i, ADS_OFS_IRQ_EN)) begin
      rdData[0] = s_q.irqEn;
    end else if (wb_adr_i[7:4] == ADS_OFS_RESULT0[7:4]) begin
      // Upper half reads zero; low six bits are zero by storage
      rdData[15:0] = s_q.result[resIdx];
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    irqSet = 1'b0;
    irqClr = 1'b0;
    lastCh = 1'b0;

    // Two-flop synchronisers for pin inputs
    s_d.trigMeta = extTrig;
    s_d.trigSync = s_q.trigMeta;
    s_d.trigPrev = s_q.trigSync;
    s_d.datMeta = adcData;
    s_d.datSync = s_q.datMeta;
    trigRise = s_q.trigSync & ~s_q.trigPrev;

    // Free-running conversion clock phase
    if ({1'b0, s_q.phase} >= 5'(tSpan - 5'h01)) begin
      s_d.phase = 4'h0;
    end else begin
      s_d.phase = s_q.phase + 4'h1;
    end

    // Bus access: one-cycle ack, writes take effect at acceptance
    s_d.wbAck = 1'b0;
    s_d.dmaReq = 1'b0;
    busAcc = wb_cyc_i & wb_stb_i & ~s_q.wbAck;
    if (busAcc) begin
      s_d.wbAck = 1'b1;
      s_d.wbDat = rdData;
      if (wb_we_i && wb_sel_i[0]) begin
        if (hit(wb_adr_i, ADS_OFS_CTRL)) begin
          s_d.ctrl.scanEn = wb_dat_i[ADS_CTRL_SCAN_ENABLE_BIT];
          s_d.ctrl.scanSel = wb_dat_i[ADS_CTRL_SCAN_SELECT_BIT];
          s_d.ctrl.clkSel = {wb_dat_i[ADS_CTRL_CKSHI],
                             wb_dat_i[ADS_CTRL_CKSLO]};
          s_d.ctrl.altClk = wb_dat_i[ADS_CTRL_ALTCK]
                            & (UNIT_INDEX != 0);
          s_d.ctrl.trigEn = wb_dat_i[ADS_CTRL_TRGEN];
        end else if (hit(wb_adr_i, ADS_OFS_CSR)) begin
          s_d.startBit = wb_dat_i[ADS_CSR_START];
          s_d.chSel = wb_dat_i[ADS_CSR_CHLO +: 4];
        end else if (hit(wb_adr_i, ADS_OFS_IRQ_CLR)) begin
          irqClr = wb_dat_i[0];
        end else if (hit(wb_adr_i, ADS_OFS_IRQ_EN)) begin
          s_d.irqEn = wb_dat_i[0];
        end
      end
    end

    // External trigger sets the start bit while idle
    if (s_q.fsm == ADS_IDLE && s_q.ctrl.trigEn && trigRise) begin
      s_d.startBit = 1'b1;
    end

    // Conversion sequencer
    unique case (s_q.fsm)
      ADS_IDLE: begin
        s_d.sampleHold = 1'b0;
        if (s_q.startBit) begin
          s_d.passDone = 1'b0;
          // First channel of the pass or the single channel
          if (s_q.ctrl.scanEn) begin
            s_d.curCh = 2'b00;
            s_d.anaCh = {s_q.chSel[3:2], 2'b00};
          end else begin
            s_d.curCh = s_q.chSel[1:0];
            s_d.anaCh = s_q.chSel;
          end
          s_d.cnt = dlyCnt - 10'h001;
          s_d.fsm = ADS_DELAY;
        end
      end
      ADS_DELAY: begin
        if (s_q.cnt == 10'h000) begin
          s_d.cnt = ADS_SPL[tIdx] - 10'h001;
          s_d.sampleHold = 1'b1;
          s_d.fsm = ADS_SAMPLE;
        end else begin
          s_d.cnt = s_q.cnt - 10'h001;
        end
      end
      ADS_SAMPLE: begin
        if (s_q.cnt == 10'h000) begin
          s_d.sampleHold = 1'b0;
          s_d.cnt = firstConv - 10'h001;
          // Single conversions and scan channel 0 of the first pass keep first-conversion timing;
          // a stale or cleared status flag must not change the choice
          if (s_q.ctrl.scanEn && (s_q.curCh != 2'b00 || s_q.passDone)) begin
            s_d.cnt = laterConv - 10'h001;
          end
          s_d.fsm = ADS_CONVERT;
        end else begin
          s_d.cnt = s_q.cnt - 10'h001;
        end
      end
      ADS_CONVERT: begin
        if (s_q.cnt == 10'h000) begin
          // Store left-justified, six low bits zero
          s_d.result[s_q.curCh] = {s_q.datSync,
                                   {ADS_RES_LSB{1'b0}}};
          if (s_q.ctrl.scanEn) begin
            lastCh = (s_q.curCh == 2'b11);
            s_d.passDone = s_q.passDone | lastCh;
            irqSet = lastCh;
            s_d.curCh = s_q.curCh + 2'b01;
            s_d.anaCh = {s_q.chSel[3:2], s_q.curCh + 2'b01};
            s_d.cnt = ADS_SPL[tIdx] - 10'h001;
            s_d.sampleHold = 1'b1;
            s_d.fsm = ADS_SAMPLE;
          end else begin
            irqSet = 1'b1;
            if (!(busAcc && wb_we_i && wb_sel_i[0]
                  && hit(wb_adr_i, ADS_OFS_CSR)
                  && wb_dat_i[ADS_CSR_START])) begin
              s_d.startBit = 1'b0;
            end
            s_d.fsm = ADS_IDLE;
          end
        end else begin
          s_d.cnt = s_q.cnt - 10'h001;
        end
      end
    endcase

    // Clearing the start bit stops any running conversion
    if (s_q.fsm != ADS_IDLE && !s_d.startBit) begin
      s_d.sampleHold = 1'b0;
      s_d.fsm = ADS_IDLE;
      irqSet = irqSet & ~s_q.ctrl.scanEn;
    end

    // Sticky status; a new event wins over a clear
    s_d.irqStat = (s_q.irqStat & ~irqClr) | irqSet;
    s_d.irqOut = s_d.irqStat & s_d.irqEn;
    s_d.dmaReq = irqSet & s_d.irqEn;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ADS_STATE_RST;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign wb_dat_o = s_q.wbDat;
  assign wb_ack_o = s_q.wbAck;
  assign sampleHold = s_q.sampleHold;
  assign anaChSel = s_q.anaCh;
  assign convEndIrq = s_q.irqOut;
  assign dmaReq = s_q.dmaReq;

endmodule

`default_nettype wire

// ===== test/ads_unit_ctrl_checker.sv
// Port-level assertions for the A/D unit control block
`timescale 1ns/10ps
`default_nettype none
module ads_unit_ctrl_checker
  import ads_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sequencer and events
  input wire logic sampleHold,
  input wire logic [3:0] anaChSel,
  input wire logic convEndIrq,
  input wire logic dmaReq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
  endsequence
  sequence resRead;
    wb_ack_o && !wb_we_i && wb_adr_i[7:4] == 4'h2;
  endsequence
  sequence splOpen;
    $rose(sampleHold);
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ack_next: assert property (busReq |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_res_low_zero: assert property (
      resRead |-> wb_dat_o[5:0] == 6'h00)
    else $error("result low bits not zero");
  a_res_width: assert property (
      resRead |-> wb_dat_o[31:16] == 16'h0000)
    else $error("result wider than 16 bits");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i == 8'hFC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_spl_hold: assert property (splOpen |-> sampleHold[*8])
    else $error("sampling phase too short");
  a_ch_steady: assert property (
      sampleHold ##1 sampleHold |-> $stable(anaChSel))
    else $error("channel moved while sampling");
  a_freeze_hold: assert property (!clkEn |=> $stable(sampleHold) &&
      $stable(anaChSel) && $stable(convEndIrq) && $stable(wb_ack_o))
    else $error("outputs moved while clock enable low");
  a_dma_pulse: assert property (dmaReq |=> !dmaReq)
    else $error("dma request not a pulse");
  a_dma_irq: assert property (dmaReq |-> ##[0:2] convEndIrq)
    else $error("dma request without interrupt");
endmodule

bind ads_unit_ctrl ads_unit_ctrl_checker uChk (
  .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sampleHold(sampleHold), .anaChSel(anaChSel),
  .convEndIrq(convEndIrq), .dmaReq(dmaReq));
`default_nettype wire

// ===== test/ads_afe_model.sv
// Analog front end model: one comparator word per channel
`timescale 1ns/10ps
`default_nettype none
module ads_afe_model
  import ads_pkg::*;
(
  // Channel and bench seed
  input wire logic [3:0] anaChSel,
  input wire logic [9:0] seedWord,
  // Converted word
  output logic [9:0] adcData
);
  // Word distinct per channel so misrouted results show
  always_comb adcData = seedWord ^ {anaChSel, anaChSel, 2'h1};
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for one A/D unit control block
`timescale 1ns/10ps
`default_nettype none
module testbench import ads_pkg::*;;
  localparam int MINT[8] = '{515, 259, 131, 67, 325, 165, 85, 45};
  localparam int MAXT[8] = '{530, 266, 134, 68, 332, 168, 87, 46};
  localparam int SPLT[8] = '{319, 159, 79, 29, 120, 60, 30, 15};
  localparam logic [7:0] RADR[5] = '{8'h00, 8'h04, 8'h08, 8'hFC, 8'h20};
  logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, extTrig;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [9:0] adcData, seedWord;
  logic [3:0] anaChSel;
  logic sampleHold, convEndIrq, dmaReq, clkEn;
  int error_cnt = 0;
  int check_count = 0;

  ads_unit_ctrl #(.UNIT_INDEX(1), .RES_W(10)) DUT (.clk_sys(clk_sys),
    .rst_n(rst_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .extTrig(extTrig), .adcData(adcData), .sampleHold(sampleHold),
    .anaChSel(anaChSel), .convEndIrq(convEndIrq), .dmaReq(dmaReq));
  ads_afe_model AFE (.anaChSel(anaChSel), .seedWord(seedWord),
    .adcData(adcData));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Expected result word of a channel
  function automatic logic [31:0] resWord(input logic [3:0] ch);
    return {16'h0, seedWord ^ {ch, ch, 2'h1}, 6'h00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Classic bus cycle; read data left in rd
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n >= 20) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // Wait for end of conversion, counting cycles and sampling cycles
  task automatic runConv(output int n, output int sh);
    n = 0;
    sh = 0;
    do begin
      @(posedge clk_sys);
      n++;
      sh += (sampleHold === 1'b1);
    end while (dmaReq !== 1'b1 && n < 800);
    if (dmaReq !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  // Main sequence
  initial begin
    int n, sh, k, tPrev, dmaCnt;
    logic [3:0] ch;
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, extTrig} = 5'h00;
    {wb_adr_i, wb_dat_i, seedWord} = '0;
    clkEn = 1'b1;
    void'($urandom(88));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1'b1, 8'h20, 32'hFFFF);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, RADR[i], 32'h0);
      chk(rd, 32'h0);
    end
    wb(1'b1, ADS_OFS_IRQ_EN, 32'h1);
    for (int c = 0; c < 8; c++) begin
      ch = 4'($urandom_range(15));
      seedWord <= 10'($urandom);
      wb(1'b1, ADS_OFS_CTRL, {27'h0, 3'(c), 2'h0});
      repeat ($urandom_range(15)) @(posedge clk_sys);
      wb(1'b1, ADS_OFS_CSR, {27'h0, ch, 1'b1});
      runConv(n, sh);
      chk(32'(n > MINT[c] && n <= MAXT[c] + 1), 32'h1);
      chk(32'(sh), 32'(SPLT[c]));
      wb(1'b0, ADS_OFS_RESULT0 + {4'h0, ch[1:0], 2'h0}, 32'h0);
      chk(rd, resWord(ch));
      wb(1'b0, ADS_OFS_CSR, 32'h0);
      chk(rd, {27'h0, ch, 1'b0});
    end
    chk({31'h0, convEndIrq}, 32'h1);
    wb(1'b1, ADS_OFS_IRQ_EN, 32'h0);
    @(posedge clk_sys);
    chk({31'h0, convEndIrq}, 32'h0);
    wb(1'b1, ADS_OFS_IRQ_CLR, 32'h1);
    wb(1'b0, ADS_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, ADS_OFS_IRQ_EN, 32'h1);
    // Four-channel scan of group 4..7
    seedWord <= 10'($urandom);
    wb(1'b1, ADS_OFS_CTRL, 32'h0D);
    wb(1'b1, ADS_OFS_CSR, 32'h0F);
    {k, n, dmaCnt, tPrev, sh} = '0;
    while (k < 8 && n < 2000) begin
      @(posedge clk_sys);
      n++;
      dmaCnt += (dmaReq === 1'b1);
      if (sampleHold === 1'b1 && sh == 0) begin
        chk({28'h0, anaChSel}, 32'(4 + k % 4));
        if (k == 1) chk(32'(n - tPrev), 32'h3F);
        if (k > 1) chk(32'(n - tPrev), 32'h40);
        tPrev = n;
        k++;
      end
      sh = (sampleHold === 1'b1);
    end
    chk(32'(dmaCnt), 32'h1);
    runConv(n, sh);
    // Stop lands well inside the next sampling phase
    repeat (10) @(posedge clk_sys);
    wb(1'b1, ADS_OFS_CSR, 32'h0E);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(ADS_OFS_RESULT0 + 4 * i), 32'h0);
      chk(rd, resWord(4'(4 + i)));
    end
    n = 0;
    repeat (200) @(posedge clk_sys) n += (sampleHold === 1'b1);
    chk(32'(n), 32'h0);
    // External trigger start
    wb(1'b1, ADS_OFS_CTRL, 32'h2C);
    wb(1'b1, ADS_OFS_CSR, 32'h04);
    extTrig <= 1'b1;
    repeat (3) @(posedge clk_sys);
    extTrig <= 1'b0;
    runConv(n, sh);
    chk(32'(sh), 32'h1D);
    wb(1'b0, 8'h28, 32'h0);
    chk(rd, resWord(4'h2));
    // Clock enable low right after the start write freezes the unit just as it enters the delay state; the run measured afterwards keeps its normal length
    wb(1'b1, ADS_OFS_CSR, 32'h03);
    clkEn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    clkEn <= 1'b1;
    runConv(n, sh);
    chk(32'(n > MINT[3] && n <= MAXT[3] + 1), 32'h1);
    chk(32'(sh), 32'h1D);
    wb(1'b0, 8'h24, 32'h0);
    chk(rd, resWord(4'h1));
    end_of_test();
  end
endmodule
`default_nettype wire
